// ==== interlock_flag_pins.sv ====
// interlock flag pins: two general flag pins with interlock handshake
// assumes one ahb-lite master, zero-wait slave, pins through pads
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
module interlock_flag_pins (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // external flag pins
    input wire logic [1:0] flagPinIn,
    output logic [1:0] flagPinOut,
    output logic [1:0] flagPinOe,
    // phase clocks
    output logic phaseOneClock,
    output logic phaseThreeClock,
    // pipeline side
    input wire logic pipelineConflict,
    output logic [23:0] storeAddr,
    output logic storeAddrValid
);
    logic rstSyncFirst;
    logic rstn;
    logic [1:0] phase;
    logic h3Tick;
    logic h1FallTick;
    logic [1:0] pinLevel;
    logic [1:0] dirBit;
    logic [1:0] outBit;
    logic [1:0] inBit;
    logic [1:0] next_dirBit;
    logic [1:0] next_outBit;
    logic [1:0] pinNextVal;
    logic [1:0] pinNextEn;
    logic dataWrite;
    logic [5:0] dataIndex;
    logic [5:0] addrIndex;
    logic addrTaken;
    logic wrCtrl;
    logic wrCmd;
    logic wrAddr;
    logic [31:0] ctrlView;
    logic [31:0] statView;
    logic [31:0] readMux;
    flag_pkg::lock_state_t state;
    flag_pkg::lock_state_t next_state;
    flag_pkg::lock_op_t op;
    flag_pkg::lock_op_t cmdOp;
    logic startCmd;
    logic lockDrive;
    logic lockLevel;
    logic ackSample;
    logic next_addrValid;
    logic busy;

    // true on the cycle that a phase begins
    function automatic logic phaseIs(input logic [1:0] now, input logic [1:0] which);
        phaseIs = (now == which);
    endfunction

    // bit position of a field of one pin in the flag control register
    function automatic int fieldBit(input int pin, input int ofs);
        fieldBit = pin * flag_pkg::FIELD_STRIDE + ofs;
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstSyncFirst <= 1'b0;
            rstn <= 1'b0;
        end
        else
        begin
            rstSyncFirst <= 1'b1;
            rstn <= rstSyncFirst;
        end
    end

    phase_gen phaseGen (
        .clk(clk),
        .rstn(rstn),
        .phase(phase),
        .phaseOneClock(phaseOneClock),
        .phaseThreeClock(phaseThreeClock)
    );

    assign h3Tick = phaseIs(phase, flag_pkg::PH_H3_RISE);
    assign h1FallTick = phaseIs(phase, flag_pkg::PH_H1_FALL);

    // pins change only at a phase three rise; the register holds the request
    genvar gi;
    generate
        for (gi = 0; gi < flag_pkg::PIN_COUNT; gi = gi + 1)
        begin : pins
            flag_pin pinCell (
                .clk(clk),
                .rstn(rstn),
                .padIn(flagPinIn[gi]),
                .padOut(flagPinOut[gi]),
                .padOe(flagPinOe[gi]),
                .applyTick(h3Tick),
                .nextVal(pinNextVal[gi]),
                .nextEn(pinNextEn[gi]),
                .levelSync(pinLevel[gi])
            );
        end
    endgenerate

    // bus address phase
    assign addrTaken = hsel && hready && (htrans == flag_pkg::HTRANS_NONSEQ);
    assign addrIndex = haddr[flag_pkg::ADDR_MSB:flag_pkg::ADDR_LSB];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dataWrite <= 1'b0;
            dataIndex <= 6'h00;
        end
        else if (hready)
        begin
            dataWrite <= addrTaken && hwrite;
            dataIndex <= addrIndex;
        end
    end

    assign wrCtrl = dataWrite && (dataIndex == flag_pkg::OFS_FLAG_CTRL[7:2]);
    assign wrCmd = dataWrite && (dataIndex == flag_pkg::OFS_LOCK_CMD[7:2]);
    assign wrAddr = dataWrite && (dataIndex == flag_pkg::OFS_STORE_ADDR[7:2]);

    // software view of the control fields
    generate
        for (gi = 0; gi < flag_pkg::PIN_COUNT; gi = gi + 1)
        begin : fields
            assign next_dirBit[gi] = wrCtrl ?
                hwdata[fieldBit(gi, flag_pkg::DIR_OFS)] : dirBit[gi];
            assign next_outBit[gi] = wrCtrl ?
                hwdata[fieldBit(gi, flag_pkg::OUT_OFS)] : outBit[gi];
            assign ctrlView[fieldBit(gi, flag_pkg::DIR_OFS)] = dirBit[gi];
            assign ctrlView[fieldBit(gi, flag_pkg::OUT_OFS)] = outBit[gi];
            assign ctrlView[fieldBit(gi, flag_pkg::IN_OFS)] = inBit[gi];
            assign ctrlView[fieldBit(gi, 0)] = 1'b0;
        end
    endgenerate
    assign ctrlView[31:8] = 24'h000000;

    // request pin is taken over by the interlock sequence at its edges
    assign pinNextVal[flag_pkg::REQ_PIN] = lockDrive ? lockLevel : next_outBit[flag_pkg::REQ_PIN];
    assign pinNextEn[flag_pkg::REQ_PIN] = lockDrive || busy || next_dirBit[flag_pkg::REQ_PIN];
    assign pinNextVal[flag_pkg::ACK_PIN] = next_outBit[flag_pkg::ACK_PIN];
    assign pinNextEn[flag_pkg::ACK_PIN] = next_dirBit[flag_pkg::ACK_PIN];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dirBit <= flag_pkg::RST_DIR;
            outBit <= flag_pkg::RST_OUT;
        end
        else
        begin
            dirBit <= next_dirBit;
            outBit <= next_outBit;
            if (lockDrive && h3Tick)
            begin
                outBit[flag_pkg::REQ_PIN] <= lockLevel;
            end
        end
    end

    // input bits follow the synchronised pin at each phase one fall
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            inBit <= 2'h0;
        end
        else if (h1FallTick)
        begin
            inBit <= pinLevel;
        end
    end

    // interlock sequencer
    assign cmdOp = flag_pkg::lock_op_t'(hwdata[flag_pkg::CMD_OP_MSB:flag_pkg::CMD_OP_LSB]);
    assign busy = (state != flag_pkg::LK_IDLE);
    // a command while busy is dropped
    assign startCmd = wrCmd && !busy && (cmdOp != flag_pkg::OP_NONE);
    assign lockDrive = h3Tick && ((state == flag_pkg::LK_WAIT_EXEC)
        || (state == flag_pkg::LK_RELEASE));
    // store and release drive high, load and signal start low
    assign lockLevel = (state == flag_pkg::LK_RELEASE) || (op == flag_pkg::OP_STORE);

    always_comb
    begin
        next_state = state;
        next_addrValid = storeAddrValid;
        case (state)
            flag_pkg::LK_IDLE:
            begin
                if (startCmd)
                begin
                    next_state = flag_pkg::LK_WAIT_EXEC;
                end
            end
            flag_pkg::LK_WAIT_EXEC:
            begin
                if (h3Tick)
                begin
                    if (op != flag_pkg::OP_STORE)
                    begin
                        next_state = flag_pkg::LK_SAMPLE;
                    end
                    else if (pipelineConflict)
                    begin
                        next_state = flag_pkg::LK_ADDR_WAIT;
                    end
                    else
                    begin
                        next_state = flag_pkg::LK_ADDR_HOLD;
                        next_addrValid = 1'b1;
                    end
                end
            end
            flag_pkg::LK_ADDR_WAIT:
            begin
                if (h3Tick && !pipelineConflict)
                begin
                    next_state = flag_pkg::LK_ADDR_HOLD;
                    next_addrValid = 1'b1;
                end
            end
            flag_pkg::LK_ADDR_HOLD:
            begin
                if (h3Tick)
                begin
                    next_state = flag_pkg::LK_IDLE;
                    next_addrValid = 1'b0;
                end
            end
            flag_pkg::LK_SAMPLE:
            begin
                if (h1FallTick)
                begin
                    next_state = (op == flag_pkg::OP_SIGNAL) ?
                        flag_pkg::LK_RELEASE : flag_pkg::LK_IDLE;
                end
            end
            flag_pkg::LK_RELEASE:
            begin
                if (h3Tick)
                begin
                    next_state = flag_pkg::LK_IDLE;
                end
            end
            default:
            begin
                next_state = flag_pkg::LK_IDLE;
                next_addrValid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= flag_pkg::LK_IDLE;
            op <= flag_pkg::OP_NONE;
            storeAddrValid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            storeAddrValid <= next_addrValid;
            if (startCmd)
            begin
                op <= cmdOp;
            end
        end
    end

    // acknowledge taken at phase one fall while sampling
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ackSample <= 1'b0;
        end
        else if (h1FallTick && (state == flag_pkg::LK_SAMPLE))
        begin
            ackSample <= pinLevel[flag_pkg::ACK_PIN];
        end
    end

    // address held steady while a store is in flight
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            storeAddr <= 24'h000000;
        end
        else if (wrAddr && !busy)
        begin
            storeAddr <= hwdata[flag_pkg::STORE_ADDR_W-1:0];
        end
    end

    // read data
    assign statView = {26'h0000000, op, 1'b0, storeAddrValid, ackSample, busy};
    assign readMux =
        (addrIndex == flag_pkg::OFS_FLAG_CTRL[7:2]) ? ctrlView :
        (addrIndex == flag_pkg::OFS_LOCK_STAT[7:2]) ? statView :
        (addrIndex == flag_pkg::OFS_STORE_ADDR[7:2]) ? {8'h00, storeAddr} :
        32'h00000000;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (addrTaken && !hwrite)
        begin
            hrdata <= readMux;
        end
    end

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = flag_pkg::HRESP_OKAY;
endmodule // interlock_flag_pins

// ==== flag_pkg.sv ====
// constants shared by the interlock flag pin block
// assumes a 32-bit ahb-lite register bus and a 100 MHz system clock
package flag_pkg;
    // register byte addresses
    localparam logic [7:0] OFS_FLAG_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOCK_CMD = 8'h04;
    localparam logic [7:0] OFS_LOCK_STAT = 8'h08;
    localparam logic [7:0] OFS_STORE_ADDR = 8'h0C;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 7;

    // flag control layout: pin n uses bits n*stride + offset
    localparam int PIN_COUNT = 2;
    localparam int FIELD_STRIDE = 4;
    localparam int DIR_OFS = 1;
    localparam int OUT_OFS = 2;
    localparam int IN_OFS = 3;
    localparam int REQ_PIN = 0;
    localparam int ACK_PIN = 1;

    // lock status layout
    localparam int STAT_BUSY = 0;
    localparam int STAT_ACK = 1;
    localparam int STAT_ADDR_VALID = 2;
    localparam int STAT_OP_LSB = 4;
    localparam int STAT_OP_MSB = 5;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_MSB = 1;
    localparam int STORE_ADDR_W = 24;

    // reset values
    localparam logic [1:0] RST_DIR = 2'h0;
    localparam logic [1:0] RST_OUT = 2'h0;
    localparam logic [1:0] RST_REQ_LEVEL = 2'h1;

    // four system clocks per instruction cycle, non-overlapping phases
    localparam int PHASE_W = 2;
    localparam logic [1:0] PH_H1_RISE = 2'h0;
    localparam logic [1:0] PH_H1_FALL = 2'h1;
    localparam logic [1:0] PH_H3_RISE = 2'h2;
    localparam logic [1:0] PH_H3_FALL = 2'h3;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {OP_NONE, OP_LOAD, OP_STORE, OP_SIGNAL} lock_op_t;
    typedef enum logic [2:0] {LK_IDLE, LK_WAIT_EXEC, LK_SAMPLE, LK_RELEASE,
        LK_ADDR_WAIT, LK_ADDR_HOLD} lock_state_t;
endpackage

// ==== phase_gen.sv ====
// two-phase clock generator: phase one and phase three outputs
// assumes clk is the system clock; phase index is a plain counter
`timescale 1ns/1ns
module phase_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // phase outputs
    output logic [1:0] phase,
    output logic phaseOneClock,
    output logic phaseThreeClock
);
    logic [1:0] next_phase;

    assign next_phase = phase + 2'h1;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase <= flag_pkg::PH_H1_RISE;
            phaseOneClock <= 1'b0;
            phaseThreeClock <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            phaseOneClock <= (next_phase == flag_pkg::PH_H1_RISE);
            phaseThreeClock <= (next_phase == flag_pkg::PH_H3_RISE);
        end
    end
endmodule // phase_gen

// ==== flag_pin.sv ====
// one external flag pin: input synchroniser and output driver
// assumes the pad turns the three signals into a two-way wire
`timescale 1ns/1ns
module flag_pin (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pad side
    input wire logic padIn,
    output logic padOut,
    output logic padOe,
    // core side
    input wire logic applyTick,
    input wire logic nextVal,
    input wire logic nextEn,
    output logic levelSync
);
    logic syncFirst;

    // only the second stage is read: the first may be metastable
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            syncFirst <= 1'b0;
            levelSync <= 1'b0;
        end
        else
        begin
            syncFirst <= padIn;
            levelSync <= syncFirst;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            padOut <= 1'b0;
            padOe <= 1'b0;
        end
        else if (applyTick)
        begin
            padOut <= nextVal;
            padOe <= nextEn;
        end
    end
endmodule // flag_pin

// ==== interlock_flag_pins_properties.sv ====
// concurrent checks on the interlock flag pin block
// assumes it is bound to the block's top and sees only its ports
`timescale 1ns/1ns
module interlock_flag_pins_properties (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // pins and pipeline
    input wire logic [1:0] flagPinIn,
    input wire logic [1:0] flagPinOut,
    input wire logic [1:0] flagPinOe,
    input wire logic phaseOneClock,
    input wire logic phaseThreeClock,
    input wire logic pipelineConflict,
    input wire logic [23:0] storeAddr,
    input wire logic storeAddrValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_oe_tick; !$stable(flagPinOe) |-> $past(phaseThreeClock); endproperty
    a_oe_tick: assert property (p_oe_tick)
        else $error("pin enable moved off the phase three tick");
    property p_out_tick; !$stable(flagPinOut) |-> $past(phaseThreeClock); endproperty
    a_out_tick: assert property (p_out_tick)
        else $error("pin level moved off the phase three tick");
    property p_bus_ok; hreadyout && hresp == flag_pkg::HRESP_OKAY; endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("bus slave stalled or gave an error");
    property p_ph3_period; phaseThreeClock |=> !phaseThreeClock [*3] ##1 phaseThreeClock; endproperty
    a_ph3_period: assert property (p_ph3_period)
        else $error("phase three tick not every four cycles");
    property p_ph1_offset; phaseThreeClock |-> ##2 phaseOneClock; endproperty
    a_ph1_offset: assert property (p_ph1_offset)
        else $error("phase one not two cycles after phase three");
    property p_addr_rise;
        $rose(storeAddrValid) |-> $past(phaseThreeClock) && flagPinOut[0] && flagPinOe[0];
    endproperty
    a_addr_rise: assert property (p_addr_rise)
        else $error("store address driven without raised request");
    property p_addr_conflict; $rose(storeAddrValid) |-> !$past(pipelineConflict); endproperty
    a_addr_conflict: assert property (p_addr_conflict)
        else $error("store address driven during a conflict");
    property p_addr_hold; $rose(storeAddrValid) |-> storeAddrValid [*4] ##1 !storeAddrValid;
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("store address not held one instruction cycle");
    property p_rdata_hold;
        !$past(hsel && htrans == flag_pkg::HTRANS_NONSEQ && !hwrite) |-> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    c_store: cover property ($rose(storeAddrValid));
    c_drive: cover property ($rose(flagPinOe[1]));
    c_req_low: cover property ($fell(flagPinOut[0]));
endmodule // interlock_flag_pins_properties

// ==== lock_arbiter.sv ====
// far side: interlock arbiter holding the acknowledge pin
// assumes a pull-up on the request pin; grant comes from the bench
`timescale 1ns/1ns
module lock_arbiter (
    // clock
    input wire logic clk,
    input wire logic phaseThreeClock,
    // arbiter decision
    input wire logic grant,
    // pin wires
    input wire logic [1:0] pinOut,
    input wire logic [1:0] pinOe,
    output logic [1:0] pinLevel
);
    logic ackLine = 1'b0;
    // change only at phase three, far from the phase one fall sample
    always_ff @(posedge clk)
        if (phaseThreeClock)
            ackLine <= grant;
    assign pinLevel[0] = pinOe[0] ? pinOut[0] : 1'b1;
    assign pinLevel[1] = pinOe[1] ? pinOut[1] : ackLine;
endmodule // lock_arbiter

// ==== interlock_flag_pins_tb_top.sv ====
// self-checking bench for the interlock flag pin block
// assumes a zero-wait bus slave and the arbiter model on the pins
`timescale 1ns/1ns
module interlock_flag_pins_tb_top;
    logic clk, resetn, hsel, hwrite, conflict, grant, lowSeen;
    logic hreadyout, hresp, ph1, ph3, addrValid;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, pinIn, pinOut, pinOe;
    logic [23:0] storeAddr;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    integer seed = 32'hA132;
    interlock_flag_pins uut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flagPinIn(pinIn),
        .flagPinOut(pinOut), .flagPinOe(pinOe), .phaseOneClock(ph1), .phaseThreeClock(ph3),
        .pipelineConflict(conflict), .storeAddr(storeAddr), .storeAddrValid(addrValid));
    lock_arbiter far (.clk(clk), .phaseThreeClock(ph3), .grant(grant), .pinOut(pinOut),
        .pinOe(pinOe), .pinLevel(pinIn));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (pinOe[0] && !pinOut[0])
            lowSeen <= 1'b1;
        if (cyc == 5000)
        begin
            error_cnt++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h0, a};
        htrans <= flag_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsel <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, flag_pkg::OFS_LOCK_STAT, 32'h0);
            n++;
        end
        while (rd[flag_pkg::STAT_BUSY] !== 1'b0 && n < 50);
        chk("idle", rd[flag_pkg::STAT_BUSY], 1'b0);
    endtask
    function automatic logic [31:0] exp_ctrl(input logic [1:0] d, input logic [1:0] o);
        logic [1:0] lvl;
        lvl[0] = d[0] ? o[0] : 1'b1;
        lvl[1] = d[1] ? o[1] : 1'b0;
        return {24'h0, lvl[1], o[1], d[1], 1'b0, lvl[0], o[0], d[0], 1'b0};
    endfunction
    initial
    begin
        logic [1:0] d, o;
        logic [31:0] e;
        logic [23:0] addr;
        int n;
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        conflict = 1'b0;
        grant = 1'b0;
        lowSeen = 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (14) @(posedge clk);
        bus(1'b0, flag_pkg::OFS_FLAG_CTRL, 32'h0);
        chk("ctrl reset", rd, exp_ctrl(flag_pkg::RST_DIR, flag_pkg::RST_OUT));
        // first four passes walk every direction pattern, the rest are random
        for (int i = 0; i < 24; i++)
        begin
            d = (i < 4) ? i[1:0] : 2'($random(seed));
            o = (i < 4) ? ~i[1:0] : 2'($random(seed));
            e = exp_ctrl(d, o);
            bus(1'b1, flag_pkg::OFS_FLAG_CTRL, {25'h0, o[1], d[1], 2'h0, o[0], d[0], 1'b0});
            repeat (12) @(posedge clk);
            chk("pin enable", pinOe, d);
            chk("pin level", pinIn, {e[7], e[3]});
            bus(1'b0, flag_pkg::OFS_FLAG_CTRL, 32'h0);
            chk("ctrl readback", rd, e);
        end
        $display("test pins done");
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        // two loads then two signals, the arbiter refusing then granting each, then one more refused load
        // request pin put back high first, else a load leaves it low and hides the pulse
        for (int k = 0; k < 5; k++)
        begin
            grant <= k[0];
            bus(1'b1, flag_pkg::OFS_FLAG_CTRL, 32'h6);
            repeat (12) @(posedge clk);
            lowSeen = 1'b0;
            bus(1'b1, flag_pkg::OFS_LOCK_CMD, (k[1] && k < 4) ? 32'h3 : 32'h1);
            wait_idle;
            chk("ack sample", rd[1:0], {k[0], 1'b0});
            chk("request pulsed", lowSeen, 1'b1);
            chk("request after", pinOut[0], k[1] && k < 4);
        end
        $display("test interlock done");
        addr = 24'($random(seed));
        // pin 0 left as input: the store must still drive it
        bus(1'b1, flag_pkg::OFS_FLAG_CTRL, 32'h0);
        conflict <= 1'b1;
        bus(1'b1, flag_pkg::OFS_STORE_ADDR, {8'h0, addr});
        bus(1'b1, flag_pkg::OFS_LOCK_CMD, 32'h2);
        repeat (12) @(posedge clk);
        chk("addr withheld", addrValid, 1'b0);
        chk("store request", {pinOe[0], pinOut[0]}, 2'h3);
        conflict <= 1'b0;
        n = 0;
        while (addrValid !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        chk("addr driven", addrValid, 1'b1);
        chk("store addr", storeAddr, addr);
        wait_idle;
        repeat (8) @(posedge clk);
        chk("store release", pinOe[0], 1'b0);
        $display("test store done");
        wrap_up;
    end
endmodule // interlock_flag_pins_tb_top
bind interlock_flag_pins interlock_flag_pins_properties u_props (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flagPinIn(flagPinIn), .flagPinOut(flagPinOut), .flagPinOe(flagPinOe),
    .phaseOneClock(phaseOneClock), .phaseThreeClock(phaseThreeClock),
    .pipelineConflict(pipelineConflict), .storeAddr(storeAddr), .storeAddrValid(storeAddrValid));
